// >>> core/pfmc_pkg.sv
// Purpose: Shared constants and carriers for the transceiver mode-control block.
// Assumes: Registers are 16 bits wide and reached through the management pins.
// Notes: Offsets are register numbers, direct below 32, indirect above.
package pfmc_pkg;
  localparam int REG_W = 16;
  localparam int ADDR_W = 12;
  localparam int HDR_BITS = 12;
  localparam int DATA_BITS = 16;
  localparam logic [11:0] OFF_BASIC_MODE_CONTROL = 12'h000;
  localparam logic [11:0] OFF_MMD_CTRL = 12'h00d;
  localparam logic [11:0] OFF_MMD_DATA = 12'h00e;
  localparam logic [11:0] OFF_TRANSCEIVER_CONTROL = 12'h010;
  localparam logic [11:0] OFF_INTERRUPT_ENABLE_MAIN = 12'h012;
  localparam logic [11:0] OFF_INTERRUPT_STATUS_MAIN = 12'h013;
  localparam logic [11:0] OFF_SELF_TEST_CONTROL = 12'h016;
  localparam logic [11:0] OFF_PIN_ROLE_CONFIG = 12'h01e;
  localparam logic [11:0] OFF_PORT_OPTIONS = 12'h031;
  localparam logic [11:0] OFF_MIRROR_SWAP_TARGET = 12'h0a0;
  localparam logic [11:0] OFF_MIRROR_SWAP_SOURCE = 12'h0a1;
  localparam logic [11:0] OFF_DEEP_POWER_DOWN_SETUP = 12'h0c6;
  localparam logic [11:0] OFF_LOOPBACK_TUNING = 12'h0fe;
  localparam logic [11:0] OFF_INTERRUPT_ENABLE_AUX = 12'hc18;
  localparam logic [11:0] OFF_INTERRUPT_STATUS_AUX = 12'hc19;
  // Field positions.
  localparam int BMC_SOFT_RESET = 15;
  localparam int BMC_MAC_LOOP = 14;
  localparam int BMC_POWER_DOWN = 11;
  localparam int XC_SLEEP_HI = 9;
  localparam int XC_SLEEP_LO = 8;
  localparam int XC_DEEP_PD = 7;
  localparam int ST_PCS_LOOP = 2;
  localparam int ST_DIGITAL_LOOP = 3;
  localparam int ST_ANALOG_LOOP = 4;
  localparam int ST_EXTERNAL_LOOP = 5;
  localparam int ST_REVERSE_LOOP = 6;
  localparam int ST_MAC_LOOP_TO_LINE = 7;
  localparam int ST_REVERSE_TO_MAC = 8;
  localparam int PR_INT_ROLE = 7;
  localparam int PO_MIRROR_EN = 0;
  // Values and codes.
  localparam logic [15:0] RST_VALUE = 16'h0000;
  localparam logic [15:0] DPD_ARM_VALUE = 16'h0010;
  localparam logic [4:0] MMD_DEVAD = 5'h1f;
  localparam logic [1:0] MMD_FN_ADDR = 2'h0;
  localparam logic [1:0] MMD_FN_INC_RW = 2'h2;
  localparam logic [1:0] MMD_FN_INC_WR = 2'h3;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] SLEEP_ACTIVE = 2'h2;
  localparam logic [1:0] SLEEP_PASSIVE = 2'h3;
  localparam logic [1:0] CH_A = 2'h0;
  localparam logic [1:0] CH_B = 2'h1;
  localparam logic [1:0] CH_C = 2'h2;
  localparam logic [1:0] CH_D = 2'h3;
  localparam logic [3:0] LANES_ALL = 4'hf;
  localparam logic [3:0] LANES_CD = 4'hc;
  typedef enum logic [1:0] {PFMC_SPD_10 = 2'h0, PFMC_SPD_100 = 2'h1, PFMC_SPD_1000 = 2'h2} pfmc_speed_t;
  typedef struct packed {
    logic [1:0] srcA;
    logic [1:0] srcB;
    logic [1:0] srcC;
    logic [1:0] srcD;
    logic [3:0] laneOn;
    logic polInv;
  } pfmc_lane_map_t;
  typedef struct packed {
    logic mac;
    logic macToLine;
    logic pcs;
    logic digital;
    logic analog;
    logic external;
    logic reverse;
    logic reverseToMac;
    logic macTxIgnore;
  } pfmc_loop_t;
  typedef struct packed {
    logic ieeePd;
    logic deepPd;
    logic crystalOff;
    logic sleepOff;
    logic nlpOn;
  } pfmc_power_t;
endpackage

// >>> core/pfmc_top.sv
// Purpose: Mirror, loopback, power-down and sleep control with a management slave.
// Assumes: Management clock well below core_clk; pins are asynchronous.
// Notes: Register side effects come at fixed points of a management frame: read clears at the turnaround, writes after the last data bit.
`timescale 1ns/1ps
module pfmc_top #(
  parameter int PHY_ADDR_W = 4,
  parameter int EVENT_W = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic [PHY_ADDR_W-1:0] phyAddrStrap,
  input wire logic mirrorStrap,
  input wire logic powerDownPinNIn,
  output logic powerDownPinNOut,
  output logic powerDownPinOe,
  input wire logic partnerDetect,
  input wire pfmc_pkg::pfmc_speed_t linkSpeed,
  input wire logic autoMdixOn,
  input wire logic [EVENT_W-1:0] eventMain,
  input wire logic [EVENT_W-1:0] eventAux,
  output pfmc_pkg::pfmc_lane_map_t laneMap,
  output pfmc_pkg::pfmc_loop_t loopSel,
  output pfmc_pkg::pfmc_power_t powerState
);
  initial begin
    if (PHY_ADDR_W < 1 || PHY_ADDR_W > 5 || EVENT_W < 1 || EVENT_W > pfmc_pkg::REG_W) begin
      $error("pfmc_top: unsupported parameter values");
    end
  end

  typedef enum {MS_IDLE, MS_START, MS_HDR, MS_TA1, MS_TA2, MS_DATA} pfmc_mstate_t;
  localparam int SYNC_W = PHY_ADDR_W + 5;

  // Pin synchronisers; no reset so the strap can be caught right after release.
  logic [SYNC_W-1:0] syncStage1_reg;
  logic [SYNC_W-1:0] syncStage2_reg;
  always_ff @(posedge core_clk) begin
    syncStage1_reg <= {mdc, mdioIn, powerDownPinNIn, partnerDetect, mirrorStrap, phyAddrStrap};
    syncStage2_reg <= syncStage1_reg;
  end
  logic mdcS, mdioS, pinNS, partnerS, mirrorS;
  logic [PHY_ADDR_W-1:0] addrS;
  assign {mdcS, mdioS, pinNS, partnerS, mirrorS, addrS} = syncStage2_reg;

  logic strapTaken_reg, mirrorStrap_reg;
  logic [PHY_ADDR_W-1:0] phyAddr_reg;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strapTaken_reg <= 1'b0;
      mirrorStrap_reg <= 1'b0;
      phyAddr_reg <= '0;
    end else if (!strapTaken_reg) begin
      strapTaken_reg <= 1'b1;
      mirrorStrap_reg <= mirrorS;
      phyAddr_reg <= addrS;
    end
  end

  logic mdcPrev_reg;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mdcPrev_reg <= 1'b0;
    end else begin
      mdcPrev_reg <= mdcS;
    end
  end
  logic mdcRise;
  assign mdcRise = mdcS && !mdcPrev_reg;

  // Register storage.
  logic [15:0] basic_reg, xcvr_reg, intEnMain_reg, intEnAux_reg, selfTest_reg, pinRole_reg;
  logic [15:0] portOpt_reg, swapTgt_reg, swapSrc_reg, dpdSetup_reg, loopTune_reg, mmdCtrl_reg, mmdAddr_reg;
  logic [15:0] intStMain_reg, intStAux_reg;
  logic softRst_reg, wrStrobe_reg, rdStrobe_reg;
  logic [15:0] wrData_reg;
  logic [4:0] regAd_reg;

  // Resolve direct and indirect addressing to one target.
  logic [11:0] tgtAddr;
  logic tgtValid, tgtIsMmdAddr;
  always_comb begin
    tgtAddr = {7'h00, regAd_reg};
    tgtValid = 1'b1;
    tgtIsMmdAddr = 1'b0;
    if (tgtAddr == pfmc_pkg::OFF_MMD_DATA) begin
      if (mmdCtrl_reg[4:0] != pfmc_pkg::MMD_DEVAD) begin
        tgtValid = 1'b0;
      end else if (mmdCtrl_reg[15:14] == pfmc_pkg::MMD_FN_ADDR) begin
        tgtIsMmdAddr = 1'b1;
      end else begin
        tgtAddr = mmdAddr_reg[11:0];
        // Indirect access to the indirection pair itself is ignored.
        if (tgtAddr == pfmc_pkg::OFF_MMD_CTRL || tgtAddr == pfmc_pkg::OFF_MMD_DATA ||
            mmdAddr_reg[15:12] != 4'h0) begin
          tgtValid = 1'b0;
        end
      end
    end
  end

  logic [15:0] readValue;
  always_comb begin
    readValue = 16'h0000;
    if (tgtIsMmdAddr) begin
      readValue = mmdAddr_reg;
    end else if (tgtValid) begin
      case (tgtAddr)
        pfmc_pkg::OFF_BASIC_MODE_CONTROL: readValue = basic_reg;
        pfmc_pkg::OFF_MMD_CTRL: readValue = mmdCtrl_reg;
        pfmc_pkg::OFF_TRANSCEIVER_CONTROL: readValue = xcvr_reg;
        pfmc_pkg::OFF_INTERRUPT_ENABLE_MAIN: readValue = intEnMain_reg;
        pfmc_pkg::OFF_INTERRUPT_STATUS_MAIN: readValue = intStMain_reg;
        pfmc_pkg::OFF_SELF_TEST_CONTROL: readValue = selfTest_reg;
        pfmc_pkg::OFF_PIN_ROLE_CONFIG: readValue = pinRole_reg;
        pfmc_pkg::OFF_PORT_OPTIONS: readValue = portOpt_reg;
        pfmc_pkg::OFF_MIRROR_SWAP_TARGET: readValue = swapTgt_reg;
        pfmc_pkg::OFF_MIRROR_SWAP_SOURCE: readValue = swapSrc_reg;
        pfmc_pkg::OFF_DEEP_POWER_DOWN_SETUP: readValue = dpdSetup_reg;
        pfmc_pkg::OFF_LOOPBACK_TUNING: readValue = loopTune_reg;
        pfmc_pkg::OFF_INTERRUPT_ENABLE_AUX: readValue = intEnAux_reg;
        pfmc_pkg::OFF_INTERRUPT_STATUS_AUX: readValue = intStAux_reg;
        default: readValue = 16'h0000;
      endcase
    end
  end

  // Management frame slave, stepped on each synchronised rising edge of mdc.
  pfmc_mstate_t mState_reg;
  logic [4:0] bitCnt_reg;
  logic [11:0] hdrShift_reg;
  logic [15:0] dataShift_reg;
  logic isRead_reg, isWrite_reg;
  logic [11:0] hdrNext;
  assign hdrNext = {hdrShift_reg[10:0], mdioS};
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mState_reg <= MS_IDLE;
      bitCnt_reg <= 5'h00;
      hdrShift_reg <= 12'h000;
      dataShift_reg <= 16'h0000;
      isRead_reg <= 1'b0;
      isWrite_reg <= 1'b0;
      regAd_reg <= 5'h00;
      mdioOut <= 1'b1;
      mdioOe <= 1'b0;
      wrStrobe_reg <= 1'b0;
      rdStrobe_reg <= 1'b0;
      wrData_reg <= 16'h0000;
    end else begin
      wrStrobe_reg <= 1'b0;
      rdStrobe_reg <= 1'b0;
      if (mdcRise) begin
        case (mState_reg)
          MS_IDLE: begin
            if (!mdioS) begin
              mState_reg <= MS_START;
            end
          end
          MS_START: begin
            if (mdioS) begin
              mState_reg <= MS_HDR;
              bitCnt_reg <= 5'h00;
            end
          end
          MS_HDR: begin
            hdrShift_reg <= hdrNext;
            bitCnt_reg <= bitCnt_reg + 5'h01;
            if (bitCnt_reg == 5'(pfmc_pkg::HDR_BITS - 1)) begin
              isRead_reg <= hdrNext[11:10] == pfmc_pkg::OP_READ && hdrNext[9:5] == 5'(phyAddr_reg);
              isWrite_reg <= hdrNext[11:10] == pfmc_pkg::OP_WRITE && hdrNext[9:5] == 5'(phyAddr_reg);
              regAd_reg <= hdrNext[4:0];
              mState_reg <= MS_TA1;
            end
          end
          MS_TA1: begin
            dataShift_reg <= readValue;
            rdStrobe_reg <= isRead_reg;
            mdioOe <= isRead_reg;
            mdioOut <= 1'b0;
            mState_reg <= MS_TA2;
          end
          MS_TA2: begin
            mdioOut <= dataShift_reg[15];
            dataShift_reg <= {dataShift_reg[14:0], 1'b0};
            bitCnt_reg <= 5'h00;
            mState_reg <= MS_DATA;
          end
          MS_DATA: begin
            bitCnt_reg <= bitCnt_reg + 5'h01;
            if (isRead_reg) begin
              mdioOut <= dataShift_reg[15];
              dataShift_reg <= {dataShift_reg[14:0], 1'b0};
            end else begin
              dataShift_reg <= {dataShift_reg[14:0], mdioS};
            end
            if (bitCnt_reg == 5'(pfmc_pkg::DATA_BITS - 1)) begin
              mState_reg <= MS_IDLE;
              mdioOe <= 1'b0;
              mdioOut <= 1'b1;
              wrStrobe_reg <= isWrite_reg;
              wrData_reg <= {dataShift_reg[14:0], mdioS};
            end
          end
          default: mState_reg <= MS_IDLE;
        endcase
      end
    end
  end

  // Register file; a soft reset returns it to defaults, which also clears power-down unless the pin still holds it.
  logic regRst;
  assign regRst = sys_rst || softRst_reg;
  logic mmdIncr;
  assign mmdIncr = regAd_reg == pfmc_pkg::OFF_MMD_DATA[4:0] && tgtValid && !tgtIsMmdAddr &&
                   ((rdStrobe_reg && mmdCtrl_reg[15:14] == pfmc_pkg::MMD_FN_INC_RW) ||
                    (wrStrobe_reg && mmdCtrl_reg[15:14] >= pfmc_pkg::MMD_FN_INC_RW));
  always_ff @(posedge core_clk) begin
    if (regRst) begin
      {basic_reg, xcvr_reg, intEnMain_reg, intEnAux_reg, selfTest_reg} <= {5{pfmc_pkg::RST_VALUE}};
      {pinRole_reg, portOpt_reg, swapTgt_reg, swapSrc_reg} <= {4{pfmc_pkg::RST_VALUE}};
      {dpdSetup_reg, loopTune_reg, mmdCtrl_reg, mmdAddr_reg} <= {4{pfmc_pkg::RST_VALUE}};
      softRst_reg <= 1'b0;
    end else begin
      softRst_reg <= 1'b0;
      if (mmdIncr) begin
        mmdAddr_reg <= mmdAddr_reg + 16'h0001;
      end
      if (wrStrobe_reg && tgtIsMmdAddr) begin
        mmdAddr_reg <= wrData_reg;
      end else if (wrStrobe_reg && tgtValid) begin
        case (tgtAddr)
          pfmc_pkg::OFF_BASIC_MODE_CONTROL: begin
            basic_reg <= wrData_reg;
            softRst_reg <= wrData_reg[pfmc_pkg::BMC_SOFT_RESET];
          end
          pfmc_pkg::OFF_MMD_CTRL: mmdCtrl_reg <= wrData_reg;
          pfmc_pkg::OFF_TRANSCEIVER_CONTROL: xcvr_reg <= wrData_reg;
          pfmc_pkg::OFF_INTERRUPT_ENABLE_MAIN: intEnMain_reg <= wrData_reg;
          pfmc_pkg::OFF_SELF_TEST_CONTROL: selfTest_reg <= wrData_reg;
          pfmc_pkg::OFF_PIN_ROLE_CONFIG: pinRole_reg <= wrData_reg;
          pfmc_pkg::OFF_PORT_OPTIONS: portOpt_reg <= wrData_reg;
          pfmc_pkg::OFF_MIRROR_SWAP_TARGET: swapTgt_reg <= wrData_reg;
          pfmc_pkg::OFF_MIRROR_SWAP_SOURCE: swapSrc_reg <= wrData_reg;
          pfmc_pkg::OFF_DEEP_POWER_DOWN_SETUP: dpdSetup_reg <= wrData_reg;
          pfmc_pkg::OFF_LOOPBACK_TUNING: loopTune_reg <= wrData_reg;
          pfmc_pkg::OFF_INTERRUPT_ENABLE_AUX: intEnAux_reg <= wrData_reg;
          default: ;
        endcase
      end
    end
  end

  // Sticky event status, cleared by a read; an event in the clearing cycle survives.
  logic clrMain, clrAux;
  assign clrMain = rdStrobe_reg && tgtValid && !tgtIsMmdAddr && tgtAddr == pfmc_pkg::OFF_INTERRUPT_STATUS_MAIN;
  assign clrAux = rdStrobe_reg && tgtValid && !tgtIsMmdAddr && tgtAddr == pfmc_pkg::OFF_INTERRUPT_STATUS_AUX;
  always_ff @(posedge core_clk) begin
    if (regRst) begin
      intStMain_reg <= pfmc_pkg::RST_VALUE;
      intStAux_reg <= pfmc_pkg::RST_VALUE;
    end else begin
      intStMain_reg <= (clrMain ? 16'h0000 : intStMain_reg) | 16'(eventMain);
      intStAux_reg <= (clrAux ? 16'h0000 : intStAux_reg) | 16'(eventAux);
    end
  end

  logic roleInt, pinPd, irqPending;
  assign roleInt = pinRole_reg[pfmc_pkg::PR_INT_ROLE];
  assign pinPd = !roleInt && !pinNS;
  assign irqPending = |(intStMain_reg & intEnMain_reg) || |(intStAux_reg & intEnAux_reg);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      powerDownPinOe <= 1'b0;
      powerDownPinNOut <= 1'b1;
    end else begin
      powerDownPinOe <= roleInt;
      powerDownPinNOut <= !irqPending;
    end
  end

  // Power-down and deep power-down.
  logic pdActive, deepArm, deepPin_reg, deepReg_reg;
  assign pdActive = basic_reg[pfmc_pkg::BMC_POWER_DOWN] || pinPd;
  assign deepArm = xcvr_reg[pfmc_pkg::XC_DEEP_PD] && pdActive && dpdSetup_reg == pfmc_pkg::DPD_ARM_VALUE;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      deepPin_reg <= 1'b0;
      deepReg_reg <= 1'b0;
    end else begin
      if (deepArm && pinPd) begin
        deepPin_reg <= 1'b1;
      end else if (softRst_reg && !pinPd) begin
        deepPin_reg <= 1'b0;
      end
      deepReg_reg <= deepArm && basic_reg[pfmc_pkg::BMC_POWER_DOWN];
    end
  end

  logic [1:0] sleepCode;
  logic sleepSel, sleeping, anyPd;
  assign sleepCode = xcvr_reg[pfmc_pkg::XC_SLEEP_HI:pfmc_pkg::XC_SLEEP_LO];
  assign sleepSel = (sleepCode == pfmc_pkg::SLEEP_ACTIVE || sleepCode == pfmc_pkg::SLEEP_PASSIVE) && !autoMdixOn;
  assign sleeping = sleepSel && !partnerS;
  assign anyPd = pdActive || deepPin_reg || deepReg_reg;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      powerState <= '0;
    end else begin
      powerState.ieeePd <= anyPd;
      powerState.deepPd <= deepPin_reg || deepReg_reg;
      powerState.crystalOff <= deepPin_reg || deepReg_reg;
      powerState.sleepOff <= sleeping;
      powerState.nlpOn <= !anyPd && !(sleeping && sleepCode == pfmc_pkg::SLEEP_PASSIVE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      loopSel <= '0;
    end else begin
      loopSel.mac <= basic_reg[pfmc_pkg::BMC_MAC_LOOP];
      loopSel.macToLine <= basic_reg[pfmc_pkg::BMC_MAC_LOOP] && selfTest_reg[pfmc_pkg::ST_MAC_LOOP_TO_LINE];
      loopSel.pcs <= selfTest_reg[pfmc_pkg::ST_PCS_LOOP] && linkSpeed != pfmc_pkg::PFMC_SPD_10;
      loopSel.digital <= selfTest_reg[pfmc_pkg::ST_DIGITAL_LOOP];
      loopSel.analog <= selfTest_reg[pfmc_pkg::ST_ANALOG_LOOP];
      loopSel.external <= selfTest_reg[pfmc_pkg::ST_EXTERNAL_LOOP] && linkSpeed != pfmc_pkg::PFMC_SPD_1000;
      loopSel.reverse <= selfTest_reg[pfmc_pkg::ST_REVERSE_LOOP];
      loopSel.macTxIgnore <= selfTest_reg[pfmc_pkg::ST_REVERSE_LOOP];
      loopSel.reverseToMac <= selfTest_reg[pfmc_pkg::ST_REVERSE_LOOP] && selfTest_reg[pfmc_pkg::ST_REVERSE_TO_MAC];
    end
  end

  logic mirrorOn;
  assign mirrorOn = mirrorStrap_reg || portOpt_reg[pfmc_pkg::PO_MIRROR_EN];
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      laneMap <= '{pfmc_pkg::CH_A, pfmc_pkg::CH_B, pfmc_pkg::CH_C, pfmc_pkg::CH_D, pfmc_pkg::LANES_ALL, 1'b0};
    end else if (!mirrorOn) begin
      laneMap <= '{pfmc_pkg::CH_A, pfmc_pkg::CH_B, pfmc_pkg::CH_C, pfmc_pkg::CH_D, pfmc_pkg::LANES_ALL, 1'b0};
    end else if (linkSpeed == pfmc_pkg::PFMC_SPD_1000) begin
      laneMap <= '{pfmc_pkg::CH_D, pfmc_pkg::CH_C, pfmc_pkg::CH_B, pfmc_pkg::CH_A, pfmc_pkg::LANES_ALL, 1'b1};
    end else begin
      // two pairs only, so pins A and B carry nothing.
      laneMap <= '{pfmc_pkg::CH_D, pfmc_pkg::CH_C, pfmc_pkg::CH_B, pfmc_pkg::CH_A, pfmc_pkg::LANES_CD, 1'b1};
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_mirror_gig;
    mirrorOn && linkSpeed == pfmc_pkg::PFMC_SPD_1000 |=> laneMap.srcA == pfmc_pkg::CH_D &&
      laneMap.srcB == pfmc_pkg::CH_C && laneMap.laneOn == pfmc_pkg::LANES_ALL;
  endproperty
  a_mirror_gig: assert property (p_mirror_gig) else $error("gigabit mirror map wrong");
  property p_mirror_fast;
    mirrorOn && linkSpeed != pfmc_pkg::PFMC_SPD_1000 |=> laneMap.srcD == pfmc_pkg::CH_A &&
      laneMap.srcC == pfmc_pkg::CH_B && laneMap.laneOn == pfmc_pkg::LANES_CD;
  endproperty
  a_mirror_fast: assert property (p_mirror_fast) else $error("10/100 mirror map wrong");
  property p_polarity;
    ##1 laneMap.polInv == $past(mirrorOn);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity does not follow mirror");
  property p_pcs_10;
    linkSpeed == pfmc_pkg::PFMC_SPD_10 |=> !loopSel.pcs;
  endproperty
  a_pcs_10: assert property (p_pcs_10) else $error("coding loopback at 10M");
  property p_ext_gig;
    linkSpeed == pfmc_pkg::PFMC_SPD_1000 |=> !loopSel.external;
  endproperty
  a_ext_gig: assert property (p_ext_gig) else $error("external loopback at gigabit");
  property p_reverse;
    selfTest_reg[pfmc_pkg::ST_REVERSE_LOOP] |=> loopSel.reverse && loopSel.macTxIgnore &&
      loopSel.reverseToMac == $past(selfTest_reg[pfmc_pkg::ST_REVERSE_TO_MAC]);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse loop still takes MAC data");
  property p_pin_pd;
    pinPd [*2] |=> powerState.ieeePd;
  endproperty
  a_pin_pd: assert property (p_pin_pd) else $error("pin did not power down");
  property p_pd_exit;
    !pdActive && !deepPin_reg ##1 !pdActive && !deepPin_reg |=> !powerState.ieeePd;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down held without cause");
  property p_passive;
    sleeping && sleepCode == pfmc_pkg::SLEEP_PASSIVE |=> !powerState.nlpOn && powerState.sleepOff;
  endproperty
  a_passive: assert property (p_passive) else $error("passive sleep sends pulses");
  property p_role;
    roleInt |=> powerDownPinOe;
  endproperty
  a_role: assert property (p_role) else $error("interrupt role pin not driven");
  c_mirror_gig: cover property (mirrorOn && linkSpeed == pfmc_pkg::PFMC_SPD_1000);
  c_deep_pd: cover property (powerState.deepPd);
  c_read_frame: cover property (rdStrobe_reg ##[1:300] !mdioOe);
  c_reverse: cover property (loopSel.reverseToMac);
endmodule

// >>> dv/pfmc_sta.sv
// Purpose: Management station model that clocks frames onto mdc and mdio.
// Assumes: Half an mdc period is four core_clk cycles; mdio has a pull-up.
// Notes: Mdc stands low between frames, so the slave never sees a free clock.
`timescale 1ns/1ps
module pfmc_sta #(
  parameter logic [4:0] PHY_ADDR = 5'h05
) (
  input wire logic core_clk,
  input wire logic mdioWire,
  output logic mdc,
  output logic staOut,
  output logic staOe
);
  initial begin
    mdc = 1'b0;
    staOut = 1'b1;
    staOe = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  // The reply is sampled at each rise; the slave changes it after the previous rise.
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] v;
    logic [17:0] tail;
    v = {32'hffffffff, 2'h1, op, PHY_ADDR, ra, 2'h2, wd};
    tail = 18'h00000;
    for (int i = 63; i >= 0; i--) begin
      staOut = v[i];
      staOe = (i > 17) || (op == 2'h1);
      half();
      mdc = 1'b1;
      tail = {tail[16:0], mdioWire};
      half();
      mdc = 1'b0;
    end
    staOe = 1'b0;
    rd = tail[15:0];
    // An idle gap keeps back-to-back frames from touching a pin twice in one time step.
    half();
  endtask
endmodule

// >>> dv/tb.sv
// Purpose: Self-checking bench for the transceiver mode-control block.
// Assumes: Strap address 5; the mirror strap is set only for the last reset.
// Notes: Table rows cover loopback and sleep codes; hand tests follow.
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [4:0] ra; logic [15:0] wd; logic [1:0] spd; logic [8:0] lp; logic [4:0] pw;} pfmc_row_t;
  logic core_clk, sys_rst, mdc, staOut, staOe, mdioOut, mdioOe, pinDrvN, pinOutN, pinOe, partnerDetect, autoMdixOn;
  logic mirrorStrap;
  logic [15:0] eventMain, eventAux, d;
  pfmc_pkg::pfmc_speed_t linkSpeed;
  pfmc_pkg::pfmc_lane_map_t laneMap;
  pfmc_pkg::pfmc_loop_t loopSel;
  pfmc_pkg::pfmc_power_t powerState;
  int miscompares = 0;
  int check_count = 0;
  wire logic mdioWire = !((mdioOe && !mdioOut) || (staOe && !staOut));
  wire logic pinWireN = pinOe ? pinOutN : pinDrvN;
  pfmc_row_t rows [12] = '{'{5'h16, 16'h0004, 2'h1, 9'h040, 5'h01}, '{5'h16, 16'h0004, 2'h0, 9'h000, 5'h01},
    '{5'h16, 16'h0008, 2'h2, 9'h020, 5'h01}, '{5'h16, 16'h0010, 2'h2, 9'h010, 5'h01},
    '{5'h16, 16'h0020, 2'h1, 9'h008, 5'h01}, '{5'h16, 16'h0020, 2'h2, 9'h000, 5'h01},
    '{5'h16, 16'h0140, 2'h2, 9'h007, 5'h01}, '{5'h16, 16'h0000, 2'h2, 9'h000, 5'h01},
    '{5'h10, 16'h0200, 2'h2, 9'h000, 5'h03}, '{5'h10, 16'h0300, 2'h2, 9'h000, 5'h02},
    '{5'h00, 16'h4000, 2'h2, 9'h100, 5'h02}, '{5'h16, 16'h0080, 2'h2, 9'h180, 5'h02}};
  pfmc_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .mdc(mdc), .mdioIn(mdioWire), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .phyAddrStrap(4'h5), .mirrorStrap(mirrorStrap), .powerDownPinNIn(pinWireN),
    .powerDownPinNOut(pinOutN), .powerDownPinOe(pinOe), .partnerDetect(partnerDetect), .linkSpeed(linkSpeed),
    .autoMdixOn(autoMdixOn), .eventMain(eventMain), .eventAux(eventAux), .laneMap(laneMap), .loopSel(loopSel),
    .powerState(powerState));
  pfmc_sta #(.PHY_ADDR(5'h05)) sta (.core_clk(core_clk), .mdioWire(mdioWire), .mdc(mdc), .staOut(staOut),
    .staOe(staOe));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic settle();
    repeat (6) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] x;
    sta.frame(pfmc_pkg::OP_WRITE, ra, wd, x);
    settle();
  endtask
  task automatic rd(input logic [4:0] ra, output logic [15:0] rv);
    sta.frame(pfmc_pkg::OP_READ, ra, 16'h0000, rv);
  endtask
  // Extended registers are reached by selecting the address, then the data window.
  task automatic xsel(input logic [11:0] a);
    wr(5'h0d, 16'h001f);
    wr(5'h0e, {4'h0, a});
    wr(5'h0d, 16'h401f);
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    sys_rst = 1'b1;
    pinDrvN = 1'b1;
    partnerDetect = 1'b0;
    autoMdixOn = 1'b0;
    eventMain = 16'h0000;
    eventAux = 16'h0000;
    mirrorStrap = 1'b0;
    linkSpeed = pfmc_pkg::PFMC_SPD_1000;
    repeat (6) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    settle();
    rd(5'h00, d);
    chk("basic_mode_control", 16'h0000, d);
    chk("loopSel", 16'h0000, 16'(loopSel));
    chk("powerState", 16'h0001, 16'(powerState));
    chk("laneMap", 16'h037e, 16'(laneMap));
    $display("test reset done");
    xsel(pfmc_pkg::OFF_LOOPBACK_TUNING);
    wr(5'h0e, 16'he720);
    foreach (rows[i]) begin
      linkSpeed = pfmc_pkg::pfmc_speed_t'(rows[i].spd);
      wr(rows[i].ra, rows[i].wd);
      chk("loopSel", 16'(rows[i].lp), 16'(loopSel));
      chk("powerState", 16'(rows[i].pw), 16'(powerState));
    end
    partnerDetect = 1'b1;
    settle();
    chk("powerState", 16'h0001, 16'(powerState));
    partnerDetect = 1'b0;
    autoMdixOn = 1'b1;
    settle();
    chk("powerState", 16'h0001, 16'(powerState));
    autoMdixOn = 1'b0;
    wr(5'h10, 16'h0000);
    $display("test table done");
    xsel(pfmc_pkg::OFF_PORT_OPTIONS);
    wr(5'h0e, 16'h0001);
    chk("laneMap", 16'h1c9f, 16'(laneMap));
    linkSpeed = pfmc_pkg::PFMC_SPD_100;
    settle();
    chk("laneMap", 16'h1c99, 16'(laneMap));
    xsel(pfmc_pkg::OFF_MIRROR_SWAP_SOURCE);
    wr(5'h0e, 16'h0a15);
    rd(5'h0e, d);
    xsel(pfmc_pkg::OFF_MIRROR_SWAP_TARGET);
    wr(5'h0e, {3'h0, d[4:0], 3'h0, d[12:8]});
    rd(5'h0e, d);
    chk("mirror_swap_target", 16'h150a, d);
    $display("test mirror done");
    pinDrvN = 1'b0;
    settle();
    chk("ieeePd", 16'h0001, 16'(powerState.ieeePd));
    wr(5'h00, 16'h0800);
    wr(5'h00, 16'h0000);
    chk("ieeePd", 16'h0001, 16'(powerState.ieeePd));
    pinDrvN = 1'b1;
    settle();
    chk("ieeePd", 16'h0000, 16'(powerState.ieeePd));
    wr(5'h10, 16'h0080);
    wr(5'h00, 16'h0800);
    chk("ieeePd", 16'h0001, 16'(powerState.ieeePd));
    xsel(pfmc_pkg::OFF_DEEP_POWER_DOWN_SETUP);
    wr(5'h0e, pfmc_pkg::DPD_ARM_VALUE);
    chk("deepPd", 16'h0003, 16'(powerState[3:2]));
    wr(5'h00, 16'h0000);
    chk("powerDown", 16'h0000, 16'(powerState[4:2]));
    $display("test power done");
    wr(5'h1e, 16'h0080);
    wr(5'h12, 16'h0001);
    eventMain = 16'h0001;
    eventAux = 16'h0001;
    @(posedge core_clk);
    #1;
    eventMain = 16'h0000;
    eventAux = 16'h0000;
    settle();
    chk("pinOe", 16'h0001, 16'(pinOe));
    chk("pinOutN", 16'h0000, 16'(pinOutN));
    wr(5'h12, 16'h0000);
    xsel(pfmc_pkg::OFF_INTERRUPT_ENABLE_AUX);
    wr(5'h0e, 16'h0000);
    rd(5'h13, d);
    chk("interrupt_status_main", 16'h0001, d);
    rd(5'h13, d);
    chk("interrupt_status_main", 16'h0000, d);
    xsel(pfmc_pkg::OFF_INTERRUPT_STATUS_AUX);
    rd(5'h0e, d);
    chk("interrupt_status_aux", 16'h0001, d);
    rd(5'h0e, d);
    chk("interrupt_status_aux", 16'h0000, d);
    repeat (625) @(posedge core_clk);
    #1;
    wr(5'h1e, 16'h0000);
    chk("pinOe", 16'h0000, 16'(pinOe));
    chk("ieeePd", 16'h0000, 16'(powerState.ieeePd));
    $display("test pin role done");
    wr(5'h05, 16'hffff);
    rd(5'h05, d);
    chk("unmapped", 16'h0000, d);
    wr(5'h00, 16'h8000);
    rd(5'h16, d);
    chk("self_test_control", 16'h0000, d);
    chk("loopSel", 16'h0000, 16'(loopSel));
    $display("test soft reset done");
    // A pin-entered deep power-down outlives the pin and needs a reset.
    wr(5'h10, 16'h0080);
    xsel(pfmc_pkg::OFF_DEEP_POWER_DOWN_SETUP);
    wr(5'h0e, pfmc_pkg::DPD_ARM_VALUE);
    pinDrvN = 1'b0;
    settle();
    pinDrvN = 1'b1;
    settle();
    chk("deepPd", 16'h0003, 16'(powerState[3:2]));
    mirrorStrap = 1'b1;
    sys_rst = 1'b1;
    settle();
    sys_rst = 1'b0;
    settle();
    chk("powerDown", 16'h0000, 16'(powerState[4:2]));
    chk("laneMap", 16'h1c99, 16'(laneMap));
    $display("test strap reset done");
    tally_and_finish();
  end
endmodule
